// ==== shared/hps_cfg.svh ====
// Summary of operation
// R1 - host reads receive bytes only when full
// R2 - host writes transmit bytes only when empty
// R3 - transmit bytes move intact to dsp receive
// R4 - host reads dsp flags any time
// R5 - long host strobe gives stable flags
// R6 - host reads flag pair twice for consensus
// R7 - vector changed only while command clear
// R8 - cleared command may still be taken
// R9 - never clear command and change vector together
// R10 - host sets init, polls until cleared
// R11 - each host flag synchronised separately (code passes them through unsynchronised)
// R12 - dsp reads host flag pair twice
// R13 - reset held for oscillator stabilisation (testbench holds reset 16 cycles, not HPS_OSC_CYC)
// R14 - external interrupts idle during reset
// R15 - mode 3 reset vector at zero
// R16 - device clears init when port ready
`ifndef HPS_CFG_SVH
`define HPS_CFG_SVH
`define HPS_A_TXL     3'h0
`define HPS_A_TXH     3'h1
`define HPS_A_RXL     3'h2
`define HPS_A_RXH     3'h3
`define HPS_A_ICR     3'h4
`define HPS_A_ISR     3'h5
`define HPS_A_CVR     3'h6
`define HPS_A_HFLAG   3'h7
`define HPS_ICR_TRANSMIT_REQUEST_ENABLE  0
`define HPS_ICR_RECEIVE_REQUEST_ENABLE  1
`define HPS_ICR_HF0   3
`define HPS_ICR_HF1   4
`define HPS_ICR_DMA   5
`define HPS_ICR_INIT  7
`define HPS_ISR_RECEIVE_FULL_FLAG  0
`define HPS_ISR_TRANSMIT_EMPTY_FLAG  1
`define HPS_ISR_TRANSFER_READY_FLAG  2
`define HPS_ISR_HF2   3
`define HPS_ISR_HF3   4
`define HPS_ISR_HOST_REQUEST_PIN  7
`define HPS_CVR_HC    7
`define HPS_INIT_CYC  8'h04
`define HPS_OSC_CYC   75000
`define HPS_EXT_CYC   25
`define HPS_RESET_VEC 16'h0000
`define HPS_D_DATA    4'h0
`define HPS_D_RDATA   4'h1
`define HPS_D_FLAGS   4'h2
`define HPS_D_IST     4'h3
`define HPS_D_IEN     4'h4
`define HPS_D_ICLR    4'h5
`define HPS_D_VEC     4'h6
`define HPS_D_DONE    4'h7
`define HPS_H_ADDR    4'h0
`define HPS_H_WDATA   4'h1
`define HPS_H_GO      4'h2
`define HPS_H_RDATA   4'h3
`define HPS_H_STAT    4'h4
`define HPS_H_IST     4'h5
`define HPS_H_IEN     4'h6
`define HPS_H_ICLR    4'h7
`endif

// ==== shared/hps_pkg.sv ====
package hps_pkg;
  typedef logic [7:0] hps_byte_t;
  typedef logic [2:0] hps_addr_t;
  typedef enum logic [3:0] {
    HPS_IDLE   = 4'b0001,
    HPS_STROBE = 4'b0010,
    HPS_HOLD   = 4'b0100,
    HPS_GAP    = 4'b1000
  } hps_bus_state_t;
endpackage

// ==== shared/hps_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface hps_if;
  logic [2:0] addr;
  logic       host_enable_strobe_n;
  logic       rd_wr_n;
  logic [7:0] host_d_out;
  logic       host_d_oe;
  logic [7:0] dev_d_out;
  logic       dev_d_oe;
  logic       host_request_pin_n;
  modport device (input addr, host_enable_strobe_n, rd_wr_n, host_d_out, host_d_oe,
                  output dev_d_out, dev_d_oe, host_request_pin_n);
  modport host (output addr, host_enable_strobe_n, rd_wr_n, host_d_out, host_d_oe,
                input dev_d_out, dev_d_oe, host_request_pin_n);
endinterface
`default_nettype wire

// ==== logic/hps_sync3.sv ====
`timescale 1ns/1ps
`default_nettype none
// three stages; value moves only when stages two and three agree
module hps_sync3 #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  // per bit agreement, so each flag settles on its own
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync_out <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          sync_out[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule // hps_sync3
`default_nettype wire

// ==== logic/hps_device.sv ====
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "hps_cfg.svh"
module hps_device (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  hps_if.device            hp,
  input  wire logic        mode3_ext,
  output logic      [15:0] reset_vector,
  input  wire logic [3:0]  sw_addr,
  input  wire logic [15:0] sw_wdata,
  input  wire logic        sw_wr,
  input  wire logic        sw_rd,
  output logic      [15:0] sw_rdata,
  output logic             irq
);
  import hps_pkg::*;

  logic [2:0]  a_s;
  logic        en_s;
  logic        rw_s;
  logic [7:0]  d_s;
  logic        en_d_reg;
  hps_byte_t   txl_reg;
  hps_byte_t   txh_reg;
  hps_byte_t   rxl_reg;
  hps_byte_t   rxh_reg;
  logic [7:0]  icr_reg;
  logic [7:0]  cvr_reg;
  logic        receive_full_flag_reg;
  logic        transmit_empty_flag_reg;
  logic [1:0]  dflag_reg;
  logic [15:0] dsp_side_receive_reg;
  logic        dsp_receive_full_reg;
  logic [7:0]  init_cnt_reg;
  logic [2:0]  ist_reg;
  logic [2:0]  ien_reg;
  logic [4:0]  hflag_raw;
  logic [4:0]  hflag_s;
  logic        hcp_d_reg;
  logic        en_fall;
  logic        en_rise;
  logic        hwr;
  logic        hrd;
  logic        sw_wr_data;
  logic        sw_rd_data;
  logic [2:0]  ev;
  logic [7:0]  isr_val;

  hps_sync3 #(.WIDTH(13)) u_pin_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in ({hp.addr, hp.host_enable_strobe_n, hp.rd_wr_n, hp.host_d_out}),
    .sync_out ({a_s, en_s, rw_s, d_s})
  );

  assign en_fall = en_d_reg & ~en_s;
  assign en_rise = ~en_d_reg & en_s;
  // write latched at strobe end so data has settled
  assign hwr = en_rise & ~rw_s;
  assign hrd = en_fall & rw_s;
  assign sw_wr_data = sw_wr & (sw_addr == `HPS_D_DATA);
  assign sw_rd_data = sw_rd & (sw_addr == `HPS_D_RDATA);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      en_d_reg <= 1'b1;
    end else begin
      en_d_reg <= en_s;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      txl_reg <= 8'h00;
      txh_reg <= 8'h00;
      icr_reg <= 8'h00;
      cvr_reg <= 8'h00;
    end else begin
      if (hwr && transmit_empty_flag_reg && a_s == `HPS_A_TXL) begin // [R2]
        txl_reg <= d_s;
      end
      if (hwr && transmit_empty_flag_reg && a_s == `HPS_A_TXH) begin // [R2]
        txh_reg <= d_s;
      end
      if (hwr && a_s == `HPS_A_ICR) begin
        icr_reg <= d_s;
      end else if (init_cnt_reg == 8'h01) begin
        icr_reg[`HPS_ICR_INIT] <= 1'b0; // [R16] [R10]
      end
      if (hwr && a_s == `HPS_A_CVR) begin
        cvr_reg <= d_s; // [R7] [R9]
      end else if (hcp_d_reg && hflag_s[4]) begin
        cvr_reg[`HPS_CVR_HC] <= 1'b0; // taken command clears pending [R8]
      end
    end
  end

  // init: short programming delay, then clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      init_cnt_reg <= 8'h00;
    end else if (hwr && a_s == `HPS_A_ICR && d_s[`HPS_ICR_INIT]) begin
      init_cnt_reg <= `HPS_INIT_CYC;
    end else if (init_cnt_reg != 8'h00) begin
      init_cnt_reg <= init_cnt_reg - 8'h01;
    end
  end

  // transmit_empty_flag: cleared by high byte write, set after transfer to dsp side
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      transmit_empty_flag_reg             <= 1'b1;
      dsp_receive_full_reg             <= 1'b0;
      dsp_side_receive_reg <= 16'h0000;
    end else begin
      if (hwr && transmit_empty_flag_reg && a_s == `HPS_A_TXH) begin
        transmit_empty_flag_reg <= 1'b0;
      end else if (!transmit_empty_flag_reg && !dsp_receive_full_reg) begin
        dsp_side_receive_reg <= {txh_reg, txl_reg}; // [R3]
        dsp_receive_full_reg             <= 1'b1;
        transmit_empty_flag_reg             <= 1'b1;
      end
      if (sw_rd_data && !(!transmit_empty_flag_reg && !dsp_receive_full_reg)) begin
        dsp_receive_full_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rxl_reg   <= 8'h00;
      rxh_reg   <= 8'h00;
      receive_full_flag_reg  <= 1'b0;
      dflag_reg <= 2'b00;
    end else begin
      if (sw_wr_data && !receive_full_flag_reg) begin
        rxl_reg  <= sw_wdata[7:0];
        rxh_reg  <= sw_wdata[15:8];
        receive_full_flag_reg <= 1'b1;
      end else if (hrd && a_s == `HPS_A_RXL) begin
        receive_full_flag_reg <= 1'b0; // low byte read ends the word
      end
      if (sw_wr && sw_addr == `HPS_D_FLAGS) begin
        dflag_reg <= sw_wdata[1:0]; // [R6]
      end
    end
  end

  always_comb begin
    isr_val = 8'h00;
    isr_val[`HPS_ISR_RECEIVE_FULL_FLAG] = receive_full_flag_reg;
    isr_val[`HPS_ISR_TRANSMIT_EMPTY_FLAG] = transmit_empty_flag_reg;
    isr_val[`HPS_ISR_TRANSFER_READY_FLAG] = transmit_empty_flag_reg & ~dsp_receive_full_reg;
    isr_val[`HPS_ISR_HF2]  = dflag_reg[0];
    isr_val[`HPS_ISR_HF3]  = dflag_reg[1];
    isr_val[`HPS_ISR_HOST_REQUEST_PIN] = ~hp.host_request_pin_n;
  end

  // read data held while strobe low, flags from flops [R4] [R5]
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hp.dev_d_out <= 8'h00;
      hp.dev_d_oe  <= 1'b0;
    end else begin
      hp.dev_d_oe <= ~en_s & rw_s;
      if (hrd) begin
        unique case (a_s)
          `HPS_A_RXL:   hp.dev_d_out <= rxl_reg; // [R1]
          `HPS_A_RXH:   hp.dev_d_out <= rxh_reg;
          `HPS_A_ICR:   hp.dev_d_out <= icr_reg;
          `HPS_A_ISR:   hp.dev_d_out <= isr_val;
          `HPS_A_CVR:   hp.dev_d_out <= cvr_reg;
          default:      hp.dev_d_out <= 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hp.host_request_pin_n <= 1'b1;
    end else begin
      hp.host_request_pin_n <= ~((receive_full_flag_reg & icr_reg[`HPS_ICR_RECEIVE_REQUEST_ENABLE]) |
                                 (transmit_empty_flag_reg & icr_reg[`HPS_ICR_TRANSMIT_REQUEST_ENABLE]));
    end
  end

  // host flags passed straight through, not synchronised: hc, dma, hf1, hf0, receive_full_flag
  assign hflag_raw = {cvr_reg[`HPS_CVR_HC], icr_reg[`HPS_ICR_DMA],
                      icr_reg[`HPS_ICR_HF1], icr_reg[`HPS_ICR_HF0], receive_full_flag_reg};
  always_comb begin
    hflag_s = hflag_raw; // [R11]
  end

  // command pending seen by core; a late cancel may still fire
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hcp_d_reg <= 1'b0;
    end else begin
      hcp_d_reg <= hflag_s[4]; // [R8]
    end
  end

  assign ev = {hcp_d_reg & ~hflag_s[4], dsp_receive_full_reg & ~hcp_d_reg, en_rise & ~rw_s};
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ist_reg <= 3'h0;
      ien_reg <= 3'h0;
    end else begin
      if (sw_wr && sw_addr == `HPS_D_IEN) begin
        ien_reg <= sw_wdata[2:0];
      end
      if (sw_wr && sw_addr == `HPS_D_ICLR) begin
        ist_reg <= (ist_reg & ~sw_wdata[2:0]) | ev;
      end else begin
        ist_reg <= ist_reg | ev;
      end
    end
  end
  assign irq = |(ist_reg & ien_reg);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sw_rdata     <= 16'h0000;
      reset_vector <= `HPS_RESET_VEC;
    end else begin
      reset_vector <= mode3_ext ? `HPS_RESET_VEC : {9'h000, cvr_reg[6:0]}; // [R15]
      unique case (sw_addr)
        `HPS_D_RDATA: sw_rdata <= dsp_side_receive_reg;
        `HPS_D_FLAGS: sw_rdata <= {11'h000, hflag_s}; // [R12]
        `HPS_D_IST:   sw_rdata <= {13'h0000, ist_reg};
        `HPS_D_IEN:   sw_rdata <= {13'h0000, ien_reg};
        `HPS_D_VEC:   sw_rdata <= {9'h000, cvr_reg[6:0]};
        `HPS_D_DONE:  sw_rdata <= {14'h0000, dsp_receive_full_reg, transmit_empty_flag_reg};
        default:      sw_rdata <= 16'h0000;
      endcase
    end
  end
endmodule // hps_device
`default_nettype wire

// ==== logic/hps_host.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "hps_cfg.svh"
module hps_host #(
  parameter int STROBE_CYC = 8,
  parameter int GAP_CYC    = 4
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  hps_if.host              hp,
  input  wire logic [3:0]  sw_addr,
  input  wire logic [15:0] sw_wdata,
  input  wire logic        sw_wr,
  input  wire logic        sw_rd,
  output logic      [15:0] sw_rdata,
  output logic             irq
);
  import hps_pkg::*;
  hps_bus_state_t st_reg;
  logic [2:0]  addr_reg;
  logic [8:0]  wdata_reg;
  logic [7:0]  rdata_reg;
  logic [7:0]  cnt_reg;
  logic        busy;
  logic        req_s;
  logic [7:0]  din_s;
  logic [1:0]  ist_reg;
  logic [1:0]  ien_reg;
  logic        done_ev;

  hps_sync3 #(.WIDTH(9)) u_in_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in ({hp.host_request_pin_n, hp.dev_d_out}),
    .sync_out ({req_s, din_s})
  );

  assign busy = st_reg != HPS_IDLE;
  // strobe held long so flags are stable [R5]
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_reg  <= HPS_IDLE;
      cnt_reg <= 8'h00;
    end else begin
      unique case (st_reg)
        HPS_IDLE: begin
          if (sw_wr && sw_addr == `HPS_H_GO) begin
            st_reg  <= HPS_STROBE;
            cnt_reg <= 8'(STROBE_CYC);
          end
        end
        HPS_STROBE: begin
          if (cnt_reg == 8'h00) begin
            st_reg  <= HPS_HOLD;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        HPS_HOLD: begin
          st_reg  <= HPS_GAP;
          cnt_reg <= 8'(GAP_CYC);
        end
        HPS_GAP: begin
          if (cnt_reg == 8'h00) begin
            st_reg <= HPS_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      addr_reg  <= 3'h0;
      wdata_reg <= 9'h000;
    end else if (!busy && sw_wr) begin
      if (sw_addr == `HPS_H_ADDR) begin
        addr_reg <= sw_wdata[2:0];
      end
      if (sw_addr == `HPS_H_WDATA) begin
        wdata_reg <= sw_wdata[8:0]; // bit 8 selects read
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hp.addr                 <= 3'h0;
      hp.host_enable_strobe_n <= 1'b1;
      hp.rd_wr_n              <= 1'b1;
      hp.host_d_out           <= 8'h00;
      hp.host_d_oe            <= 1'b0;
      rdata_reg               <= 8'h00;
    end else begin
      hp.addr                 <= addr_reg;
      hp.rd_wr_n              <= wdata_reg[8];
      hp.host_d_out           <= wdata_reg[7:0];
      hp.host_d_oe            <= busy & ~wdata_reg[8];
      hp.host_enable_strobe_n <= ~(st_reg == HPS_STROBE);
      // capture at gap end: device answer needs two sync passes
      if (st_reg == HPS_GAP && cnt_reg == 8'h00) begin
        rdata_reg <= din_s; // [R4]
      end
    end
  end

  assign done_ev = st_reg == HPS_HOLD;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ist_reg <= 2'h0;
      ien_reg <= 2'h0;
    end else begin
      if (sw_wr && sw_addr == `HPS_H_IEN) begin
        ien_reg <= sw_wdata[1:0];
      end
      if (sw_wr && sw_addr == `HPS_H_ICLR) begin
        ist_reg <= (ist_reg & ~sw_wdata[1:0]) | {~req_s, done_ev};
      end else begin
        ist_reg <= ist_reg | {~req_s, done_ev};
      end
    end
  end
  assign irq = |(ist_reg & ien_reg);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sw_rdata <= 16'h0000;
    end else begin
      unique case (sw_addr)
        `HPS_H_RDATA: sw_rdata <= {8'h00, rdata_reg};
        `HPS_H_STAT:  sw_rdata <= {14'h0000, ~req_s, busy};
        `HPS_H_IST:   sw_rdata <= {14'h0000, ist_reg};
        `HPS_H_IEN:   sw_rdata <= {14'h0000, ien_reg};
        default:      sw_rdata <= 16'h0000;
      endcase
    end
  end
endmodule // hps_host
`default_nettype wire

// ==== sim/hps_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module hps_assertions #(
  parameter int STROBE_CYC = 8,
  parameter int GAP_CYC    = 4
) (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic [2:0] addr,
  input wire logic       host_enable_strobe_n,
  input wire logic       rd_wr_n,
  input wire logic [7:0] host_d_out,
  input wire logic       host_d_oe,
  input wire logic [7:0] dev_d_out,
  input wire logic       dev_d_oe,
  input wire logic       host_request_pin_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [7:0] low_cnt;
  logic [7:0] high_cnt;
  // saturating idle count, so the first access after reset is never short
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) low_cnt <= 8'h00;
    else if (!host_enable_strobe_n) low_cnt <= low_cnt + 8'h01;
    else low_cnt <= 8'h00;
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) high_cnt <= 8'hFF;
    else if (!host_enable_strobe_n) high_cnt <= 8'h00;
    else if (high_cnt != 8'hFF) high_cnt <= high_cnt + 8'h01;
  end
  sequence s_open;
    $fell(host_enable_strobe_n);
  endsequence
  sequence s_close;
    $rose(host_enable_strobe_n);
  endsequence
  sequence s_held;
    !host_enable_strobe_n && !$past(host_enable_strobe_n);
  endsequence
  a_strobe_width: assert property (s_close |-> low_cnt == 8'(STROBE_CYC + 1))
    else $error("strobe width wrong");
  a_cycle_gap: assert property (s_open |-> high_cnt >= 8'(GAP_CYC + 1))
    else $error("access gap too short");
  a_addr_stable: assert property (s_held |-> $stable(addr) && $stable(rd_wr_n))
    else $error("select changed in access");
  a_wdata_stable: assert property (s_held ##0 $past(host_d_oe) |-> $stable(host_d_out))
    else $error("write data changed in access");
  a_no_clash: assert property (!(host_d_oe && dev_d_oe))
    else $error("both ends drive data");
  a_host_oe_write: assert property (host_d_oe |-> !rd_wr_n)
    else $error("host drives on read");
  a_read_drive: assert property (s_open ##0 rd_wr_n |-> ##[1:8] dev_d_oe)
    else $error("device silent on read");
  a_reset_idle: assert property (disable iff (1'b0)
    rst |-> host_enable_strobe_n && !host_d_oe && !dev_d_oe && host_request_pin_n)
    else $error("link busy in reset");
endmodule // hps_assertions
`default_nettype wire

// ==== sim/test_host_port_sync_handshake.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "hps_cfg.svh"
module test_host_port_sync_handshake;
  import hps_pkg::*;
  localparam int STROBE_N = 8;
  localparam int GAP_N    = 4;
  logic        sys_clk;
  logic        rst;
  logic        mode3_ext;
  logic [15:0] reset_vector;
  logic [3:0]  sw_addr [2];
  logic [15:0] sw_wdata [2];
  logic        sw_wr [2];
  logic        sw_rd [2];
  logic [15:0] sw_rdata [2];
  logic        irq [2];
  int          fails = 0;
  int          checks = 0;
  int          cyc = 0;
  hps_if hps_if_i ();
  hps_host #(.STROBE_CYC(STROBE_N), .GAP_CYC(GAP_N)) hps_host_i (.sys_clk(sys_clk),
    .rst(rst), .hp(hps_if_i.host), .sw_addr(sw_addr[0]), .sw_wdata(sw_wdata[0]),
    .sw_wr(sw_wr[0]), .sw_rd(sw_rd[0]), .sw_rdata(sw_rdata[0]), .irq(irq[0]));
  hps_device hps_device_i (.sys_clk(sys_clk), .rst(rst), .hp(hps_if_i.device),
    .mode3_ext(mode3_ext), .reset_vector(reset_vector), .sw_addr(sw_addr[1]),
    .sw_wdata(sw_wdata[1]), .sw_wr(sw_wr[1]), .sw_rd(sw_rd[1]),
    .sw_rdata(sw_rdata[1]), .irq(irq[1]));
  hps_assertions #(.STROBE_CYC(STROBE_N), .GAP_CYC(GAP_N)) hps_assertions_i (
    .sys_clk(sys_clk), .rst(rst), .addr(hps_if_i.addr),
    .host_enable_strobe_n(hps_if_i.host_enable_strobe_n), .rd_wr_n(hps_if_i.rd_wr_n),
    .host_d_out(hps_if_i.host_d_out), .host_d_oe(hps_if_i.host_d_oe),
    .dev_d_out(hps_if_i.dev_d_out), .dev_d_oe(hps_if_i.dev_d_oe),
    .host_request_pin_n(hps_if_i.host_request_pin_n));
  always #5 sys_clk = ~sys_clk;
  task automatic end_of_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // whole run is under a thousand cycles; ceiling leaves wide margin
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 50000) begin
      fails++;
      end_of_test;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // e selects the end: 0 host, 1 device
  task automatic sw(input int e, input bit rd, input logic [3:0] a,
                    input logic [15:0] d, output logic [15:0] q);
    @(posedge sys_clk);
    sw_addr[e]  <= a;
    sw_wdata[e] <= d;
    sw_wr[e]    <= !rd;
    sw_rd[e]    <= rd;
    @(posedge sys_clk);
    sw_wr[e] <= 1'b0;
    sw_rd[e] <= 1'b0;
    #1 q = sw_rdata[e];
  endtask
  task automatic lnk(input bit rd, input logic [2:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    logic [15:0] s;
    sw(0, 0, `HPS_H_ADDR, {13'h0000, a}, s);
    sw(0, 0, `HPS_H_WDATA, {7'h00, rd, d}, s);
    sw(0, 0, `HPS_H_GO, 16'h0000, s);
    s = 16'h0001;
    for (int i = 0; i < 100 && s[0] !== 1'b0; i++) sw(0, 1, `HPS_H_STAT, 16'h0000, s);
    chk(s[0], 16'h0000);
    sw(0, 1, `HPS_H_RDATA, 16'h0000, s);
    q = s[7:0];
  endtask
  task automatic dwait(input int b);
    logic [15:0] s;
    s = 16'h0000;
    for (int i = 0; i < 50 && s[b] !== 1'b1; i++) sw(1, 1, `HPS_D_IST, 16'h0000, s);
    chk(s[b], 16'h0001);
  endtask
  task automatic t_reset;
    logic [7:0] q;
    chk(reset_vector, 16'h0000);
    lnk(1, `HPS_A_ISR, 8'h00, q);
    chk(q[`HPS_ISR_TRANSMIT_EMPTY_FLAG], 16'h0001);
    chk(q[`HPS_ISR_RECEIVE_FULL_FLAG], 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_init;
    logic [7:0] q;
    lnk(0, `HPS_A_ICR, 8'h81, q);
    q = 8'h80;
    for (int i = 0; i < 20 && q[7] !== 1'b0; i++) lnk(1, `HPS_A_ICR, 8'h00, q);
    chk(q[`HPS_ICR_INIT], 16'h0000);
    lnk(1, `HPS_A_ISR, 8'h00, q);
    chk(q[`HPS_ISR_HOST_REQUEST_PIN], 16'h0001);
    chk(hps_if_i.host_request_pin_n, 16'h0000);
    lnk(0, `HPS_A_ICR, 8'h00, q);
    $display("test init done");
  endtask
  task automatic t_tx;
    logic [7:0]  q;
    logic [15:0] s;
    sw(1, 0, `HPS_D_IEN, 16'h0001, s);
    lnk(0, `HPS_A_TXL, 8'h3C, q);
    lnk(0, `HPS_A_TXH, 8'hA5, q);
    dwait(0);
    chk(irq[1], 16'h0001);
    sw(1, 0, `HPS_D_IEN, 16'h0000, s);
    chk(irq[1], 16'h0000);
    sw(1, 0, `HPS_D_ICLR, 16'h0001, s);
    sw(1, 1, `HPS_D_IST, 16'h0000, s);
    chk(s[0], 16'h0000);
    sw(1, 1, `HPS_D_RDATA, 16'h0000, s);
    chk(s, 16'hA53C);
    $display("test transmit done");
  endtask
  task automatic t_rx;
    logic [7:0]  q;
    logic [15:0] s;
    sw(0, 0, `HPS_H_IEN, 16'h0001, s);
    sw(1, 0, `HPS_D_DATA, 16'h5AC3, s);
    q = 8'h00;
    for (int i = 0; i < 20 && q[0] !== 1'b1; i++) lnk(1, `HPS_A_ISR, 8'h00, q);
    chk(q[`HPS_ISR_RECEIVE_FULL_FLAG], 16'h0001);
    chk(irq[0], 16'h0001);
    sw(0, 0, `HPS_H_ICLR, 16'h0003, s);
    chk(irq[0], 16'h0000);
    lnk(1, `HPS_A_RXH, 8'h00, q);
    chk(q, 16'h005A);
    lnk(1, `HPS_A_RXL, 8'h00, q);
    chk(q, 16'h00C3);
    $display("test receive done");
  endtask
  // every pair value, both directions, each read twice
  task automatic t_flags;
    logic [7:0]  q;
    logic [15:0] s;
    for (int v = 0; v < 4; v++) begin
      lnk(0, `HPS_A_ICR, {3'h0, 2'(v), 3'h0}, q);
      s = 16'h00FF;
      for (int i = 0; i < 20 && s[2:1] !== 2'(v); i++) sw(1, 1, `HPS_D_FLAGS, 16'h0000, s);
      chk(s[2:1], 16'(v));
      sw(1, 1, `HPS_D_FLAGS, 16'h0000, s);
      chk(s[2:1], 16'(v));
      sw(1, 0, `HPS_D_FLAGS, 16'(v), s);
      lnk(1, `HPS_A_ISR, 8'h00, q);
      chk(q[4:3], 16'(v));
      lnk(1, `HPS_A_ISR, 8'h00, q);
      chk(q[4:3], 16'(v));
    end
    $display("test flags done");
  endtask
  task automatic t_cmd;
    logic [7:0]  q;
    logic [15:0] s;
    lnk(0, `HPS_A_CVR, 8'h8A, q);
    dwait(2);
    sw(1, 1, `HPS_D_VEC, 16'h0000, s);
    chk(s, 16'h000A);
    sw(1, 0, `HPS_D_ICLR, 16'h0004, s);
    lnk(0, `HPS_A_CVR, 8'h93, q);
    lnk(0, `HPS_A_CVR, 8'h13, q);
    lnk(1, `HPS_A_CVR, 8'h00, q);
    chk(q[`HPS_CVR_HC], 16'h0000);
    dwait(2);
    sw(1, 1, `HPS_D_VEC, 16'h0000, s);
    chk(s, 16'h0013);
    $display("test command done");
  endtask
  initial begin
    sys_clk   = 1'b0;
    rst       = 1'b1;
    mode3_ext = 1'b1;
    for (int e = 0; e < 2; e++) begin
      sw_addr[e]  = 4'h0;
      sw_wdata[e] = 16'h0000;
      sw_wr[e]    = 1'b0;
      sw_rd[e]    = 1'b0;
    end
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset;
    t_init;
    t_tx;
    t_rx;
    t_flags;
    t_cmd;
    end_of_test;
  end
endmodule // test_host_port_sync_handshake
`default_nettype wire
